// File: design/lafs_pkg.sv
/*
 * lafs_pkg: shared constants and types of the load-adaptive full-step
 * commutation block.
 * assumes one 100 MHz clock and inputs synchronous to it.
 */
package lafs_pkg;

   // ==========================================================
   // widths
   localparam int VEL_W  = 23;   // velocity 0 .. 2^23-1
   localparam int ACC_W  = 24;   // phase accumulator, carry = one microstep
   localparam int MSC_W  = 10;   // microstep counter
   localparam int WAIT_W = 12;   // cycles since the last commutation
   localparam int LOAD_W = 9;    // load value 0 .. 511

   // ==========================================================
   // counts and limits
   localparam logic [7:0]        USTEP_PER_FS_M1 = 8'hff;   // 256 ticks per full step
   localparam logic [MSC_W-1:0]  FS_STEP         = 10'h100; // one full step in microsteps
   localparam logic [MSC_W-1:0]  USTEP           = 10'h001;
   localparam logic [3:0]        TOFF_CAP        = 4'h8;    // off-time ceiling in mode
   localparam logic [WAIT_W-1:0] BLANK_BASE      = 12'h010; // blank = base + sel * step
   localparam logic [WAIT_W-1:0] BLANK_STEP      = 12'h008;
   localparam logic [WAIT_W-1:0] WAIT_MAX        = 12'hfff;
   localparam logic [7:0]        LOAD_SAT        = 8'hff;
   localparam logic [VEL_W-1:0]  VEL_ZERO        = 23'h000000;

   // ==========================================================
   // state
   typedef enum logic [1:0] {
      MODE_MICRO,
      MODE_FULL,
      MODE_HALT
   } lafs_mode_e;

   typedef struct packed {
      lafs_mode_e         mode;
      logic [ACC_W-1:0]   nom_acc;
      logic [ACC_W-1:0]   min_acc;
      logic [7:0]         nom_cnt;
      logic [7:0]         min_cnt;
      logic               due;
      logic               acked;
      logic [WAIT_W-1:0]  wait_cnt;
      logic [MSC_W-1:0]   msc;
      logic               step;
      logic               stall;
      logic               event_stop;
      logic [LOAD_W-1:0]  load;
      logic               load_valid;
      logic [VEL_W-1:0]   vact;
      logic [3:0]         toff;
      logic               fullstep;
      logic               const_toff;
      logic               mode_active;
      logic               sin_pos;
      logic               cos_pos;
   } lafs_state_s;

   localparam lafs_state_s STATE_RST = '0;

endpackage : lafs_pkg

// File: design/lafs_commutation.sv
/*
 * lafs_commutation: load-adaptive full-step commutation. Above the minimum
 * mode velocity it steps in full steps with a constant off-time chopper,
 * waits for the bridge's back-EMF acknowledge of each step, slows when that
 * acknowledge is late and never drops below the minimum velocity.
 * assumes: the ramp generator supplies the target velocity, the bridge
 * comparator pulses bemf_ack_in once per full step, all inputs synchronous.
 */
`timescale 1ns/1ns

module lafs_commutation (
   input  wire logic                        mclk_in,                 // 100 MHz clock
   input  wire logic                        rst_in,                  // sync reset, high
   input  wire logic                        internal_ramp_in,        // 1: ramp gen drives
   input  wire logic                        dir_in,                  // 1: count up
   input  wire logic [lafs_pkg::VEL_W-1:0]  target_velocity_in,      // ramp target
   input  wire logic [lafs_pkg::VEL_W-1:0]  min_mode_velocity_in,    // mode threshold
   input  wire logic [lafs_pkg::VEL_W-1:0]  load_meas_low_vel_thresh_in, // load meas min
   input  wire logic                        vhigh_fullstep_in,       // full-step flag
   input  wire logic                        vhigh_chopper_in,        // chopper-switch flag
   input  wire logic                        silent_chop_en_in,       // voltage-mode chopper
   input  wire logic [3:0]                  toff_in,                 // off-time setting
   input  wire logic [1:0]                  blank_time_sel_in,       // blanking select
   input  wire logic [9:0]                  load_ref_pulse_width_in, // reference pulse
   input  wire logic [7:0]                  stall_sensitivity_in,    // stall sensitivity
   input  wire logic                        stop_on_stall_en_in,     // stop on stall
   input  wire logic                        stall_stop_event_clear_in, // clear pulse
   input  wire logic                        general_stall_in,        // general detector
   input  wire logic                        bemf_ack_in,             // step acknowledge
   output logic [lafs_pkg::MSC_W-1:0]       microstep_counter_out,   // wave position
   output logic                             step_out,                // step pulse
   output logic                             fullstep_out,            // full stepping
   output logic                             const_toff_out,          // const off-time chop
   output logic [3:0]                       toff_eff_out,            // effective off-time
   output logic                             mode_active_out,         // mode running
   output logic [lafs_pkg::VEL_W-1:0]       actual_velocity_out,     // actual velocity
   output logic                             stall_out,               // stall pulse
   output logic                             stall_stop_event_out,    // stop event flag
   output logic [lafs_pkg::LOAD_W-1:0]      load_value_out,          // load value
   output logic                             load_valid_out,          // load value valid
   output logic                             sin_pos_out,             // coil a polarity
   output logic                             cos_pos_out              // coil b polarity
);

   // ==========================================================
   // helpers
   function automatic logic [lafs_pkg::ACC_W:0] acc_add(
      input logic [lafs_pkg::ACC_W-1:0] acc,
      input logic [lafs_pkg::VEL_W-1:0] vel
   );
      acc_add = {1'b0, acc} + {2'b00, vel};
   endfunction : acc_add

   function automatic logic [7:0] sat8(input logic [lafs_pkg::WAIT_W-1:0] v);
      sat8 = (v[11:10] != 2'b00) ? lafs_pkg::LOAD_SAT : v[9:2];
   endfunction : sat8

   // ==========================================================
   // state
   lafs_pkg::lafs_state_s state_reg;
   lafs_pkg::lafs_state_s state_next;

   logic [lafs_pkg::ACC_W:0]  nom_sum;
   logic [lafs_pkg::ACC_W:0]  min_sum;
   logic                      nom_tick;
   logic                      min_tick;
   logic                      mode_ok;
   logic                      stall_now;
   logic                      commute;
   logic                      forced;
   logic [lafs_pkg::WAIT_W-1:0] blank_cyc;
   logic [lafs_pkg::WAIT_W-1:0] ref_cyc;
   logic [lafs_pkg::WAIT_W-1:0] stall_cyc;
   logic [lafs_pkg::WAIT_W:0]   stall_sum;
   logic [lafs_pkg::MSC_W-1:0]  msc_delta;

   always_comb begin
      state_next = state_reg;
      state_next.step  = 1'b0;
      state_next.stall = 1'b0;
      stall_now = 1'b0;
      commute   = 1'b0;
      forced    = 1'b0;
      nom_sum   = acc_add(state_reg.nom_acc, target_velocity_in);
      min_sum   = acc_add(state_reg.min_acc, min_mode_velocity_in);
      nom_tick  = nom_sum[lafs_pkg::ACC_W];
      min_tick  = min_sum[lafs_pkg::ACC_W];
      state_next.nom_acc = nom_sum[lafs_pkg::ACC_W-1:0];
      state_next.min_acc = min_sum[lafs_pkg::ACC_W-1:0];
      // ack before the blanking window is chopper noise, not the motor
      blank_cyc = lafs_pkg::BLANK_BASE
                + (lafs_pkg::BLANK_STEP * {10'h000, blank_time_sel_in});
      // a reference shorter than blanking would read every step as overload
      ref_cyc = ({2'b00, load_ref_pulse_width_in} > blank_cyc)
              ? {2'b00, load_ref_pulse_width_in} : blank_cyc + 12'h001;
      // higher sensitivity lowers the late-ack limit that counts as stall
      // saturate: a wrapped limit would read every step as a stall
      stall_sum = {1'b0, ref_cyc} + {1'b0, (8'hff - stall_sensitivity_in), 4'h0};
      stall_cyc = stall_sum[lafs_pkg::WAIT_W] ? lafs_pkg::WAIT_MAX
                : stall_sum[lafs_pkg::WAIT_W-1:0];
      msc_delta = dir_in ? lafs_pkg::USTEP : -lafs_pkg::USTEP;

      mode_ok = internal_ramp_in
              && vhigh_fullstep_in && vhigh_chopper_in
              && !silent_chop_en_in
              && (min_mode_velocity_in != lafs_pkg::VEL_ZERO)
              && (target_velocity_in > min_mode_velocity_in);

      case (state_reg.mode)
         lafs_pkg::MODE_MICRO: begin
            if (nom_tick) begin
               state_next.msc  = state_reg.msc + msc_delta;
               state_next.step = 1'b1;
            end
            stall_now = general_stall_in;
            if (mode_ok) begin
               state_next.mode     = lafs_pkg::MODE_FULL;
               state_next.nom_cnt  = 8'h00;
               state_next.min_cnt  = 8'h00;
               state_next.due      = 1'b0;
               // no full step is owed an ack yet, so entry is not a stall
               state_next.acked    = 1'b1;
               state_next.wait_cnt = '0;
            end
         end
         lafs_pkg::MODE_FULL: begin
            if (!mode_ok) begin
               state_next.mode = lafs_pkg::MODE_MICRO;
            end else begin
               if (state_reg.wait_cnt != lafs_pkg::WAIT_MAX) begin
                  state_next.wait_cnt = state_reg.wait_cnt + 12'h001;
               end
               // nominal full-step period from the target velocity
               if (nom_tick && !state_reg.due) begin
                  state_next.nom_cnt = state_reg.nom_cnt + 8'h01;
                  if (state_reg.nom_cnt == lafs_pkg::USTEP_PER_FS_M1) begin
                     state_next.due = 1'b1;
                  end
               end
               // minimum-velocity period runs in parallel as a floor
               if (min_tick) begin
                  state_next.min_cnt = state_reg.min_cnt + 8'h01;
               end
               if (bemf_ack_in && !state_reg.acked
                   && (state_reg.wait_cnt >= blank_cyc)) begin
                  state_next.acked = 1'b1;
                  if (state_reg.wait_cnt <= ref_cyc) begin
                     state_next.load = {1'b0, sat8(state_reg.wait_cnt)};
                  end else begin
                     state_next.load = {1'b1, sat8(state_reg.wait_cnt - ref_cyc)};
                  end
                  state_next.load_valid =
                     (target_velocity_in >= load_meas_low_vel_thresh_in);
                  stall_now = (state_reg.wait_cnt > stall_cyc);
               end
               // late ack holds the step back, so the motor slows itself
               commute = state_reg.due && state_reg.acked;
               // no ack by the floor period: motor blocked, step anyway
               forced = min_tick && (state_reg.min_cnt == lafs_pkg::USTEP_PER_FS_M1)
                      && !state_reg.acked;
               if (forced) begin
                  stall_now = 1'b1;
               end
               if (commute || forced) begin
                  state_next.msc      = dir_in ? state_reg.msc + lafs_pkg::FS_STEP
                                               : state_reg.msc - lafs_pkg::FS_STEP;
                  state_next.step     = 1'b1;
                  state_next.due      = 1'b0;
                  state_next.acked    = 1'b0;
                  state_next.nom_cnt  = 8'h00;
                  state_next.min_cnt  = 8'h00;
                  state_next.wait_cnt = '0;
               end
            end
         end
         lafs_pkg::MODE_HALT: begin
            // no motion until software releases the stop
            if (!state_reg.event_stop || !stop_on_stall_en_in) begin
               state_next.mode = lafs_pkg::MODE_MICRO;
            end
         end
         default: begin
            state_next = lafs_pkg::STATE_RST;
         end
      endcase

      state_next.stall = stall_now;
      // a stall with stop-on-stall enabled in the same cycle as the clear keeps the flag set
      if (stall_now && stop_on_stall_en_in) begin
         state_next.event_stop = 1'b1;
         state_next.mode       = lafs_pkg::MODE_HALT;
      end else if (stall_stop_event_clear_in) begin
         state_next.event_stop = 1'b0;
      end
      // without stop-on-stall nothing halts, so released load resumes motion
      if (!stop_on_stall_en_in && state_next.mode == lafs_pkg::MODE_HALT) begin
         state_next.mode = lafs_pkg::MODE_MICRO;
      end

      state_next.mode_active = (state_next.mode == lafs_pkg::MODE_FULL);
      state_next.fullstep    = state_next.mode_active;
      state_next.const_toff  = state_next.mode_active;
      state_next.toff = (state_next.mode_active && toff_in > lafs_pkg::TOFF_CAP)
                      ? lafs_pkg::TOFF_CAP : toff_in;
      state_next.vact = (state_next.mode == lafs_pkg::MODE_HALT)
                      ? lafs_pkg::VEL_ZERO : target_velocity_in;
      if (!state_next.mode_active) begin
         state_next.load_valid = 1'b0;
      end
      // polarity follows the wave layout the commutation relies on
      state_next.sin_pos = (state_next.msc[9:8] == 2'b00)
                         || (state_next.msc[9:8] == 2'b11);
      state_next.cos_pos = !state_next.msc[9];
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         state_reg <= lafs_pkg::STATE_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // outputs
   assign microstep_counter_out = state_reg.msc;
   assign step_out              = state_reg.step;
   assign fullstep_out          = state_reg.fullstep;
   assign const_toff_out        = state_reg.const_toff;
   assign toff_eff_out          = state_reg.toff;
   assign mode_active_out       = state_reg.mode_active;
   assign actual_velocity_out   = state_reg.vact;
   assign stall_out             = state_reg.stall;
   assign stall_stop_event_out  = state_reg.event_stop;
   assign load_value_out        = state_reg.load;
   assign load_valid_out        = state_reg.load_valid;
   assign sin_pos_out           = state_reg.sin_pos;
   assign cos_pos_out           = state_reg.cos_pos;

endmodule : lafs_commutation

// File: verif/lafs_commutation_asserts.sv
/* checker for lafs_commutation: gating, strides, off-time cap, stall stop.
   assumes binding to the top module ports, one clock, sync high reset. */
`timescale 1ns/1ns
module lafs_commutation_asserts (
   input wire logic                       mclk_in,                   // clock
   input wire logic                       rst_in,                    // reset
   input wire logic                       internal_ramp_in,          // ramp
   input wire logic [lafs_pkg::VEL_W-1:0] target_velocity_in,        // target
   input wire logic [lafs_pkg::VEL_W-1:0] min_mode_velocity_in,      // floor
   input wire logic                       vhigh_fullstep_in,         // flag
   input wire logic                       vhigh_chopper_in,          // flag
   input wire logic                       silent_chop_en_in,         // silent
   input wire logic [3:0]                 toff_in,                   // off-time
   input wire logic                       stop_on_stall_en_in,       // stop
   input wire logic                       stall_stop_event_clear_in, // clear
   input wire logic                       general_stall_in,          // stall
   input wire logic [lafs_pkg::MSC_W-1:0] microstep_counter_out,     // position
   input wire logic                       step_out,                  // step
   input wire logic                       fullstep_out,              // full
   input wire logic                       const_toff_out,            // chopper
   input wire logic [3:0]                 toff_eff_out,              // off-time
   input wire logic                       mode_active_out,           // mode
   input wire logic [lafs_pkg::VEL_W-1:0] actual_velocity_out,       // velocity
   input wire logic                       stall_out,                 // stall
   input wire logic                       stall_stop_event_out,      // event
   input wire logic                       sin_pos_out,               // coil a
   input wire logic                       cos_pos_out                // coil b
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   logic mode_ok;
   assign mode_ok = internal_ramp_in && vhigh_fullstep_in && vhigh_chopper_in &&
                    !silent_chop_en_in && (min_mode_velocity_in != '0) &&
                    (target_velocity_in > min_mode_velocity_in);
   // ==========================================
   // mode entry and exit
   chk_mode_gate: assert property (!mode_ok |=> !mode_active_out)
      else $error("mode active without all enables");
   chk_mode_entry: assert property (mode_ok && !mode_active_out && !stall_stop_event_out
      && actual_velocity_out != lafs_pkg::VEL_ZERO && !(general_stall_in && stop_on_stall_en_in)
      |=> mode_active_out)
      else $error("mode not entered");
   chk_chop_full: assert property (fullstep_out == mode_active_out
      && const_toff_out == mode_active_out)
      else $error("full step or chopper not tied to mode");
   chk_toff_cap: assert property (mode_active_out |-> toff_eff_out ==
      (($past(toff_in) > 4'h8) ? 4'h8 : $past(toff_in)))
      else $error("off-time not capped");
   chk_full_stride: assert property (step_out && fullstep_out && $past(fullstep_out) |->
      10'(microstep_counter_out - $past(microstep_counter_out)) inside {10'h100, 10'h300})
      else $error("full step stride wrong");
   chk_micro_stride: assert property (step_out && !fullstep_out && !$past(fullstep_out)
      |-> 10'(microstep_counter_out - $past(microstep_counter_out)) inside {10'h001, 10'h3ff})
      else $error("microstep stride wrong");
   // ==========================================
   // stall stop
   chk_stall_halt: assert property (stall_out && $past(stop_on_stall_en_in) |->
      stall_stop_event_out && actual_velocity_out == lafs_pkg::VEL_ZERO)
      else $error("stall did not stop");
   chk_halt_hold: assert property (stall_stop_event_out && stop_on_stall_en_in &&
      !stall_stop_event_clear_in |=> !step_out && actual_velocity_out == lafs_pkg::VEL_ZERO)
      else $error("motion while halted");
   chk_event_hold: assert property (stall_stop_event_out && !stall_stop_event_clear_in
      |=> stall_stop_event_out)
      else $error("event lost");
   chk_event_clear: assert property (stall_stop_event_clear_in
      |=> !stall_stop_event_out || stall_out)
      else $error("event not cleared");
   chk_gen_stall: assert property (!mode_active_out && !stall_stop_event_out
      && actual_velocity_out != lafs_pkg::VEL_ZERO
      && stop_on_stall_en_in && general_stall_in |=> stall_out && stall_stop_event_out)
      else $error("general stall ignored");
   chk_wave_sign: assert property (!$past(rst_in)
      |-> cos_pos_out == !microstep_counter_out[9]
      && sin_pos_out == (microstep_counter_out[9:8] inside {2'h0, 2'h3}))
      else $error("coil polarity wrong");
   cov_full_step: cover property (step_out && fullstep_out);
   cov_stall_stop: cover property (stall_out && stall_stop_event_out);
   cov_clear: cover property (stall_stop_event_out && stall_stop_event_clear_in);
endmodule : lafs_commutation_asserts

// File: verif/lafs_motor_model.sv
/* lafs_motor_model: rotor stand-in answering each full step with one
   acknowledge after a set delay, none while blocked.
   assumes step_in is a one-cycle pulse on mclk_in. */
`timescale 1ns/1ns
module lafs_motor_model (
   input  wire logic        mclk_in,     // clock
   input  wire logic        rst_in,      // sync reset
   input  wire logic        step_in,     // step pulse
   input  wire logic        fullstep_in, // full stepping
   input  wire logic [11:0] delay_in,    // step to ack
   input  wire logic        blocked_in,  // rotor held
   output logic             bemf_ack_out // ack pulse
);
   logic [11:0] cnt_reg;
   logic        armed_reg;
   // a held rotor makes no back-emf, so its step goes unanswered
   always_ff @(posedge mclk_in) begin
      bemf_ack_out <= 1'b0;
      if (rst_in || !fullstep_in) begin
         armed_reg <= 1'b0;
      end else if (step_in) begin
         armed_reg <= 1'b1;
         cnt_reg   <= delay_in;
      end else if (armed_reg && cnt_reg != 12'h000) begin
         cnt_reg <= cnt_reg - 12'h001;
      end else if (armed_reg) begin
         armed_reg    <= 1'b0;
         bemf_ack_out <= !blocked_in;
      end
   end
endmodule : lafs_motor_model

// File: verif/lafs_commutation_bench.sv
/* bench for lafs_commutation: gating, timing, overload, blocked rotor, stop.
   assumes lafs_motor_model answers the steps. */
`timescale 1ns/1ns
module lafs_commutation_bench;
   localparam logic [22:0] TGT  = 23'h400000; // full step per 1024 cycles
   localparam logic [22:0] MINV = 23'h100000; // full step per 4096 cycles
   logic mclk_in = 1'b0, rst_in = 1'b1, blocked = 1'b0, bemf_ack_in, dir = 1'b1;
   logic internal_ramp_in = 1'b1, vhigh_fullstep_in = 1'b1, vhigh_chopper_in = 1'b1;
   logic silent_chop_en_in = 1'b0, stop_on_stall_en_in = 1'b0, general_stall_in = 1'b0;
   logic stall_stop_event_clear_in = 1'b0, step_out, fullstep_out, const_toff_out;
   logic mode_active_out, stall_out, stall_stop_event_out, load_valid_out, sin_pos_out;
   logic cos_pos_out;
   logic [22:0] target_velocity_in = TGT, min_mode_velocity_in = MINV, actual_velocity_out;
   logic [9:0]  microstep_counter_out, msc0;
   logic [8:0]  load_value_out;
   logic [7:0]  stall_sensitivity_in = 8'h00;
   logic [11:0] delay = 12'h01e;
   logic [3:0]  toff_eff_out;
   int          num_errors = 0, samples_checked = 0, stall_cnt = 0, gap;
   lafs_commutation lafs_commutation_i (.mclk_in, .rst_in, .internal_ramp_in, .dir_in(dir),
      .target_velocity_in, .min_mode_velocity_in, .load_meas_low_vel_thresh_in(23'h100001),
      .vhigh_fullstep_in, .vhigh_chopper_in, .silent_chop_en_in, .toff_in(4'hf),
      .blank_time_sel_in(2'h0), .load_ref_pulse_width_in(10'h028), .stall_sensitivity_in,
      .stop_on_stall_en_in, .stall_stop_event_clear_in, .general_stall_in, .bemf_ack_in,
      .microstep_counter_out, .step_out, .fullstep_out, .const_toff_out, .toff_eff_out,
      .mode_active_out, .actual_velocity_out, .stall_out, .stall_stop_event_out,
      .load_value_out, .load_valid_out, .sin_pos_out, .cos_pos_out);
   lafs_motor_model lafs_motor_model_i (.mclk_in, .rst_in, .step_in(step_out),
      .fullstep_in(fullstep_out), .delay_in(delay), .blocked_in(blocked),
      .bemf_ack_out(bemf_ack_in));
   initial forever #5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) if (stall_out === 1'b1) stall_cnt++;
   // ==========================================
   // tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask : cyc
   // gap ends as the cycles from the previous step to the last one
   task automatic steps(input int n);
      repeat (n) begin
         gap = 0;
         do begin
            cyc(1);
            gap++;
         end while (step_out !== 1'b1 && gap < 6000);
      end
   endtask : steps
   task automatic wait_ev();
      for (int k = 0; k < 6000 && stall_stop_event_out !== 1'b1; k++) cyc(1);
   endtask : wait_ev
   task automatic clear_ev();
      stall_stop_event_clear_in = 1'b1;
      cyc(1);
      stall_stop_event_clear_in = 1'b0;
      cyc(2);
      check("event cleared", stall_stop_event_out, 1'b0);
   endtask : clear_ev
   task automatic close_out();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   initial begin
      #1000000;
      num_errors++;
      close_out();
   end
   // ==========================================
   // tests
   initial begin
      cyc(8);
      rst_in = 1'b0;
      for (int i = 0; i < 7; i++) begin
         internal_ramp_in = (i != 0);
         vhigh_fullstep_in = (i != 1);
         vhigh_chopper_in = (i != 2);
         silent_chop_en_in = (i == 3);
         min_mode_velocity_in = (i == 4) ? 23'h000000 : MINV;
         target_velocity_in = (i == 5) ? MINV : TGT;
         cyc(4);
         check("mode active", mode_active_out, i == 6);
      end
      check("off-time", toff_eff_out, 4'h8);
      steps(2);
      msc0 = microstep_counter_out;
      steps(1);
      check("period", gap inside {[1020:1030]}, 1);
      check("stride", 10'(microstep_counter_out - msc0), 10'h100);
      check("load", {load_valid_out, load_value_out <= 9'h0ff}, 2'h3);
      delay = 12'h5dc;
      steps(2);
      check("slowed", gap inside {[1450:1600]}, 1);
      check("slip load", load_value_out, 9'h1ff);
      check("no stall", stall_cnt, 0);
      delay = 12'h0c8;
      stall_sensitivity_in = 8'hff;
      steps(2);
      check("sensitive", stall_cnt > 0, 1);
      stall_sensitivity_in = 8'h00;
      blocked = 1'b1;
      steps(2);
      check("floor", gap inside {[4000:4200]}, 1);
      blocked = 1'b0;
      steps(3);
      check("restart", gap inside {[1020:1030]}, 1);
      stop_on_stall_en_in = 1'b1;
      blocked = 1'b1;
      wait_ev();
      check("halt velocity", actual_velocity_out, 23'h000000);
      check("event", stall_stop_event_out, 1'b1);
      msc0 = microstep_counter_out;
      cyc(2000);
      check("held", microstep_counter_out, msc0);
      blocked = 1'b0;
      clear_ev();
      check("velocity back", actual_velocity_out, TGT);
      blocked = 1'b1;
      wait_ev();
      stop_on_stall_en_in = 1'b0;
      steps(2);
      check("resumed", gap < 4200, 1);
      check("event kept", stall_stop_event_out, 1'b1);
      clear_ev();
      blocked = 1'b0;
      min_mode_velocity_in = 23'h000000;
      stop_on_stall_en_in = 1'b1;
      steps(2);
      msc0 = microstep_counter_out;
      steps(1);
      check("micro stride", 10'(microstep_counter_out - msc0), 10'h001);
      check("off-time micro", toff_eff_out, 4'hf);
      msc0 = microstep_counter_out;
      dir = 1'b0;
      steps(1);
      check("micro down", 10'(microstep_counter_out - msc0), 10'h3ff);
      general_stall_in = 1'b1;
      cyc(1);
      general_stall_in = 1'b0;
      cyc(1);
      check("general stall", stall_stop_event_out, 1'b1);
      clear_ev();
      close_out();
   end
endmodule : lafs_commutation_bench
bind lafs_commutation lafs_commutation_asserts lafs_commutation_asserts_i (.mclk_in, .rst_in,
   .internal_ramp_in, .target_velocity_in, .min_mode_velocity_in, .vhigh_fullstep_in,
   .vhigh_chopper_in, .silent_chop_en_in, .toff_in, .stop_on_stall_en_in,
   .stall_stop_event_clear_in, .general_stall_in, .microstep_counter_out, .step_out,
   .fullstep_out, .const_toff_out, .toff_eff_out, .mode_active_out, .actual_velocity_out,
   .stall_out, .stall_stop_event_out, .sin_pos_out, .cos_pos_out);
